// ===== splc_consts.vh
// Functional notes
// - Working register fifteen is the stack pointer for every push and pop.
// - Pointer holds next free word; stack grows toward higher addresses.
// - Pop decrements before the access; push increments after the write.
// - Call pushes zero-extend the counter, so the upper word's top byte is clear; the low word is pushed whole.
// - Exception pushes put the status low byte in the upper word's top byte.
// - Limit register gets no defined value from reset.
// - Bit zero of pointer and limit is forced to zero.
// - Only push effective addresses formed from the pointer are compared with the limit; pops are not.
// - Push at pointer equal to limit is fine; the next push traps.
// - Pointer address below 0x0800 raises an underflow stack error.
`ifndef SPLC_CONSTS_VH
`define SPLC_CONSTS_VH
`define SPLC_ADDR_SP      8'h1E
`define SPLC_ADDR_LIM     8'h20
`define SPLC_ADDR_STAT    8'h40
`define SPLC_ADDR_MASK    8'h42
`define SPLC_SP_RST       16'h0800
`define SPLC_SFR_TOP      16'h0800
`define SPLC_WORD_STEP    16'h0002
`define SPLC_ALIGN_MASK   16'hFFFE
`define SPLC_BIT_OVF      0
`define SPLC_BIT_UNF      1
`define SPLC_OP_NONE      2'h0
`define SPLC_OP_PUSH      2'h1
`define SPLC_OP_POP       2'h2
`define SPLC_OP_LOAD      2'h3
`define SPLC_PK_DATA      2'h0
`define SPLC_PK_CALL      2'h1
`define SPLC_PK_EXC       2'h2
`endif

// ===== splc_limit_cmp.v
`include "splc_consts.vh"

// Compares one effective address against the limit and the special function space
module splc_limit_cmp #(
  parameter W = 16
) (
  input  wire [W-1:0] ea_i,      // Effective address from the pointer
  input  wire [W-1:0] lim_i,     // Aligned limit value
  input  wire         push_i,    // Address belongs to a push
  output wire         ovf_o,     // Overflow past the limit
  output wire         unf_o      // Underflow into special function space
);

  // Strictly greater, so a push exactly at the limit passes
  assign ovf_o = push_i && (ea_i > lim_i);
  assign unf_o = (ea_i < `SPLC_SFR_TOP);

endmodule // splc_limit_cmp

// ===== splc_stack_ptr.v
`include "splc_consts.vh"

module splc_stack_ptr #(
  parameter W = 16
) (
  input  wire         clk_sys_i,   // Core clock
  input  wire         srst_i,      // Synchronous reset, active high
  input  wire [7:0]   reg_addr_i,  // Register address
  input  wire [W-1:0] reg_wdata_i, // Register write data
  input  wire         reg_wr_i,    // Register write strobe
  input  wire         reg_rd_i,    // Register read strobe
  output reg  [W-1:0] reg_rdata_o, // Read data, cycle after strobe
  input  wire [1:0]   stk_op_i,    // None, push, pop, load pointer
  input  wire [1:0]   push_kind_i, // Data, call low/high, exception
  input  wire         push_hi_i,   // Push carries counter upper word
  input  wire [W-1:0] push_data_i, // Data or counter word to push
  input  wire [7:0]   srl_i,       // Status low byte
  input  wire [W-1:0] sp_load_i,   // New pointer for a load
  output wire [W-1:0] ea_o,        // Effective address of this access
  output wire [W-1:0] wr_data_o,   // Word to write on a push
  output wire         wr_en_o,     // Push write enable
  output reg          trap_o,      // Stack error trap pulse
  output wire [W-1:0] sp_o,        // Current stack pointer
  output wire         irq_o        // Level interrupt
);

  reg  [W-1:0] sp_r;
  reg  [W-1:0] sp_nxt;
  reg  [W-1:0] lim_r;
  reg  [1:0]   stat_r;
  reg  [1:0]   mask_r;
  reg  [1:0]   stat_nxt;
  reg  [W-1:0] wdat;
  wire         is_push;
  wire         is_pop;
  wire         ovf;
  wire         unf;
  wire [1:0]   evt;

  // Word alignment applied wherever a pointer or limit is stored
  function [W-1:0] align;
    input [W-1:0] v;
    begin
      align = v & `SPLC_ALIGN_MASK;
    end
  endfunction

  assign is_push = (stk_op_i == `SPLC_OP_PUSH);
  assign is_pop  = (stk_op_i == `SPLC_OP_POP);

  // Push writes at the pointer, pop reads one word below it
  assign ea_o = is_pop ? (sp_r - `SPLC_WORD_STEP) : sp_r;
  assign sp_o = sp_r;

  splc_limit_cmp #(
    .W      (W)
  ) u_cmp (
    .ea_i   (ea_o),
    .lim_i  (lim_r),
    .push_i (is_push),
    .ovf_o  (ovf),
    .unf_o  (unf)
  );

  // Only pointer accesses are checked; idle cycles raise nothing
  assign evt = {unf && (is_push || is_pop), ovf};

  // Build the pushed word by kind
  always @* begin
    wdat = push_data_i;
    case (push_kind_i)
      `SPLC_PK_CALL: begin
        if (push_hi_i) wdat = {8'h00, push_data_i[7:0]};
      end
      `SPLC_PK_EXC: begin
        if (push_hi_i) wdat = {srl_i, push_data_i[7:0]};
      end
      default: wdat = push_data_i;
    endcase
  end

  assign wr_data_o = wdat;
  // A trapping push still writes; the trap handler sees the state
  assign wr_en_o = is_push;

  // Pointer next value
  always @* begin
    sp_nxt = sp_r;
    case (stk_op_i)
      `SPLC_OP_PUSH: sp_nxt = sp_r + `SPLC_WORD_STEP;
      `SPLC_OP_POP:  sp_nxt = sp_r - `SPLC_WORD_STEP;
      `SPLC_OP_LOAD: sp_nxt = align(sp_load_i);
      default:       sp_nxt = sp_r;
    endcase
    if (reg_wr_i && reg_addr_i == `SPLC_ADDR_SP) sp_nxt = align(reg_wdata_i);
  end

  // Pointer register and trap pulse
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      sp_r   <= `SPLC_SP_RST;
      trap_o <= 1'b0;
    end else begin
      sp_r   <= align(sp_nxt);
      trap_o <= |evt;
    end
  end

  // Limit has no reset branch: software must load it before use
  always @(posedge clk_sys_i) begin
    if (reg_wr_i && reg_addr_i == `SPLC_ADDR_LIM) lim_r <= align(reg_wdata_i);
  end

  // Sticky status: a new event beats a same-cycle write-one clear
  always @* begin
    stat_nxt = stat_r;
    if (reg_wr_i && reg_addr_i == `SPLC_ADDR_STAT) stat_nxt = stat_r & ~reg_wdata_i[1:0];
    stat_nxt = stat_nxt | evt;
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      stat_r <= 2'h0;
      mask_r <= 2'h0;
    end else begin
      stat_r <= stat_nxt;
      if (reg_wr_i && reg_addr_i == `SPLC_ADDR_MASK) mask_r <= reg_wdata_i[1:0];
    end
  end

  assign irq_o = |(stat_r & mask_r);

  // Read port; unmapped reads return zero. Limit reads undefined before first write.
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_o <= {W{1'b0}};
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SPLC_ADDR_SP:   reg_rdata_o <= sp_r;
        `SPLC_ADDR_LIM:  reg_rdata_o <= lim_r;
        `SPLC_ADDR_STAT: reg_rdata_o <= {{(W-2){1'b0}}, stat_r};
        `SPLC_ADDR_MASK: reg_rdata_o <= {{(W-2){1'b0}}, mask_r};
        default:         reg_rdata_o <= {W{1'b0}};
      endcase
    end else begin
      reg_rdata_o <= {W{1'b0}};
    end
  end

endmodule // splc_stack_ptr

// ===== splc_core_model.sv
// Stack memory of the core; always reads the word at the effective address, unclocked
module splc_core_model (
  input  wire logic        clk_sys_i, // Core clock
  input  wire logic        wr_en_i,   // Push write
  input  wire logic [15:0] ea_i,      // Effective address
  input  wire logic [15:0] wr_data_i, // Pushed word
  output wire logic [15:0] rd_data_o  // Word at the address
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_r [0:255];
  // Words land at address bits 8:1, so addresses 512 bytes apart share one word
  always @(posedge clk_sys_i) begin
    if (wr_en_i) mem_r[ea_i[8:1]] <= wr_data_i;
  end
  assign rd_data_o = mem_r[ea_i[8:1]];
endmodule // splc_core_model

// ===== splc_check_monitor.sv
module splc_check (
  input wire logic        clk_sys_i, srst_i, reg_wr_i, push_hi_i, wr_en_o, trap_o, // Controls
  input wire logic [7:0]  reg_addr_i, srl_i,                      // Address, status byte
  input wire logic [1:0]  stk_op_i, push_kind_i,                  // Op and push kind
  input wire logic [15:0] reg_wdata_i, ea_o, wr_data_o, sp_o      // Words
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lim_r; // Shadow of the limit, unknown until written
  // Track limit writes; X until then keeps antecedents false
  always @(posedge clk_sys_i) begin
    if (reg_wr_i && reg_addr_i == 8'h20) lim_r <= reg_wdata_i & 16'hFFFE;
  end
  wire psh = stk_op_i == 2'h1 && !reg_wr_i; // Register write would override
  wire pop = stk_op_i == 2'h2 && !reg_wr_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sp_align_a: assert property (!sp_o[0]) else $error("pointer odd");
  push_step_a: assert property (psh |=> sp_o == $past(sp_o) + 16'h0002) else $error("push");
  pop_step_a: assert property (pop |=> sp_o == $past(sp_o) - 16'h0002) else $error("pop");
  push_addr_a: assert property (psh |-> ea_o == sp_o && wr_en_o) else $error("ea");
  call_top_a: assert property (psh && push_kind_i == 2'h1 && push_hi_i |-> wr_data_o[15:8] == 8'h00)
    else $error("call byte");
  exc_top_a: assert property (psh && push_kind_i == 2'h2 && push_hi_i |-> wr_data_o[15:8] == srl_i)
    else $error("exc byte");
  under_trap_a: assert property (pop && sp_o == 16'h0800 |=> trap_o) else $error("under");
  over_trap_a: assert property (psh && sp_o > lim_r |=> trap_o) else $error("over");
  at_limit_a: assert property (psh && sp_o <= lim_r && sp_o >= 16'h0800 |=> !trap_o)
    else $error("spurious");
  cover property (psh && sp_o > lim_r);
  cover property (pop && sp_o == 16'h0800);
  cover property (psh && push_kind_i == 2'h2 && push_hi_i);
endmodule // splc_check
bind splc_stack_ptr splc_check u_chk (.*);

// ===== test_stack_pointer_limit_check.sv
module test_stack_pointer_limit_check;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, wr = 0, rd = 0, ph = 0, rd_d = 0;
  logic [1:0] op = 0, pk = 0;
  logic [7:0] adr = 0, status_low_byte = 0;
  logic [15:0] wd = 0, pd = 0, ld = 0, lim;
  wire [15:0] rdat, ea, wdo, sp;
  wire we, trap, irq;
  int errors = 0, checks = 0;
  logic [15:0] q[$];
  initial forever #2 clk = ~clk;
  splc_stack_ptr dut (.clk_sys_i(clk), .srst_i(srst), .reg_addr_i(adr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .stk_op_i(op), .push_kind_i(pk),
    .push_hi_i(ph), .push_data_i(pd), .srl_i(status_low_byte), .sp_load_i(ld), .ea_o(ea), .wr_data_o(wdo),
    .wr_en_o(we), .trap_o(trap), .sp_o(sp), .irq_o(irq));
  splc_core_model u_core (.clk_sys_i(clk), .wr_en_i(we), .ea_i(ea), .wr_data_i(wdo), .rd_data_o());
  task chk(input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  // One cycle of stimulus; random words keep the pushed data honest
  task t(input [1:0] o, input w, r, input [7:0] a, input [15:0] d);
    @(posedge clk); op <= o; wr <= w; rd <= r; adr <= a; wd <= d; ld <= d;
    pd <= $urandom; status_low_byte <= $urandom;
    @(posedge clk); op <= 0; wr <= 0; rd <= 0;
  endtask
  task rdx(input [7:0] a, input [15:0] e); q.push_back(e); t(0, 0, 1, a, 0); endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk(rdat, q.pop_front());
    rd_d <= rd;
  end
  task give_verdict;
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin #40000; errors++; give_verdict; end
  initial begin
    void'($urandom(32'h65921139));
    repeat (12) @(posedge clk);
    srst <= 0;
    rdx(8'h1E, 16'h0800);
    rdx(8'h50, 16'h0000);
    lim = 16'h0A00 | ($urandom & 16'h01FF);
    t(0, 1, 0, 8'h20, lim);
    rdx(8'h20, lim & 16'hFFFE);
    t(3, 0, 0, 8'h00, lim & 16'hFFFE);
    pk <= 1; ph <= 1;
    t(1, 0, 0, 8'h00, 0);
    #1 chk(trap, 0);
    rdx(8'h40, 16'h0000);
    pk <= 2;
    t(1, 0, 0, 8'h00, 0);
    #1 chk(trap, 1);
    rdx(8'h40, 16'h0001);
    #1 chk(irq, 0);
    t(0, 1, 0, 8'h42, 16'h0001); #1 chk(irq, 1);
    t(0, 1, 0, 8'h40, 16'h0001); #1 chk(irq, 0);
    t(3, 0, 0, 8'h00, 16'h0800);
    t(2, 0, 0, 8'h00, 0);
    #1 chk(trap, 1);
    rdx(8'h40, 16'h0002);
    #1 chk(irq, 0);
    rdx(8'h1E, 16'h07FE);
    t(0, 1, 0, 8'h1E, 16'h0A01);
    rdx(8'h1E, 16'h0A00);
    // Let the last read answer be compared before closing
    repeat (2) @(posedge clk);
    chk(q.size(), 0);
    give_verdict;
  end
endmodule // test_stack_pointer_limit_check
